//--- include/mbs_pkg.sv
// Constants for the max-address and block-size command logic.
// Assumes an APB slave with byte addresses and 8-bit task-file bytes.
package mbs_pkg;
   localparam int          ADDR_W          = 8;
   localparam logic [7:0]  OPC_SET_MAX_EXT = 8'h37;
   localparam logic [7:0]  OPC_SET_MULT    = 8'hc6;

   // Task-file bytes, one word each from offset zero upward.
   localparam int          TF_N            = 8;
   localparam int          TF_SC_CUR       = 0;
   localparam int          TF_SC_PREV      = 1;
   localparam int          TF_LBA0         = 2;
   localparam logic [7:0]  OFS_TF_END      = 8'h20;
   localparam logic [7:0]  OFS_CMD_STAT    = 8'h20;
   localparam logic [7:0]  OFS_ERROR       = 8'h24;
   localparam logic [7:0]  OFS_IRQ_STAT    = 8'h28;
   localparam logic [7:0]  OFS_IRQ_MASK    = 8'h2c;
   localparam logic [7:0]  OFS_MAX_LO      = 8'h30;
   localparam logic [7:0]  OFS_MAX_HI      = 8'h34;
   localparam logic [7:0]  OFS_MULT        = 8'h38;

   // Status, error and sector-count field positions.
   localparam int          ST_BSY          = 7;
   localparam int          ST_RDY          = 6;
   localparam int          ST_SEEK_DONE    = 4;
   localparam int          ST_ERR          = 0;
   localparam int          ERR_ABORT       = 2;
   localparam int          SC_NV_BIT       = 0;

   // Interrupt status and mask layout.
   localparam int          IRQ_W           = 3;
   localparam int          IRQ_DONE        = 0;
   localparam int          IRQ_ABORT       = 1;
   localparam int          IRQ_REJECT      = 2;
   localparam logic [2:0]  IRQ_MASK_RST    = 3'h0;

   localparam logic [47:0] LBA28_LIMIT     = 48'd268435455;
   localparam logic [7:0]  MULT_MAX        = 8'h10;
   localparam logic [7:0]  MULT_RST        = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } mbs_state_t;
endpackage

//--- src/mbs_cmd_core.sv
// Command logic for the extended max-address set and the block-size set.
// Assumes an APB master on CLK_SYS and firmware that drives the lock inputs.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module mbs_cmd_core #(
   parameter logic [47:0] NATIVE_MAX_LBA    = 48'h0000_ffff_ffff,
   parameter bit          EXT_SUPPORTED     = 1'b1,
   parameter logic [7:0]  OPC_RD_NATIVE_EXT = 8'h27
) (
   input  wire logic                       CLK_SYS,
   input  wire logic                       RST,
   input  wire logic                       PSEL,
   input  wire logic                       PENABLE,
   input  wire logic                       PWRITE,
   input  wire logic [mbs_pkg::ADDR_W-1:0] PADDR,
   input  wire logic [31:0]                PWDATA,
   output logic      [31:0]                PRDATA,
   output logic                            PREADY,
   output logic                            PSLVERR,
   output logic                            IRQ,
   input  wire logic                       OFFSET_MODE,
   input  wire logic                       SETMAX_LOCKED,
   input  wire logic                       SETMAX_FROZEN,
   input  wire logic                       HPA28_ACTIVE,
   input  wire logic [47:0]                NV_MAX_LBA,
   output logic                            NV_STORE,
   output logic      [47:0]                NV_STORE_LBA,
   output logic      [63:0]                ID_W100_103,
   output logic      [31:0]                ID_W60_61,
   output logic                            MULT_EN,
   output logic      [7:0]                 MULT_BLOCK,
   input  wire logic                       ACCESS_REQ,
   input  wire logic [47:0]                ACCESS_LBA,
   output logic                            ACCESS_REJECT
);
   import mbs_pkg::*;

   localparam logic [31:0] ID60_RST = (NATIVE_MAX_LBA > LBA28_LIMIT) ?
                                      LBA28_LIMIT[31:0] : NATIVE_MAX_LBA[31:0];

   mbs_state_t        state_r;
   mbs_state_t        state_nxt;
   logic [7:0]        tf_r [TF_N];
   logic [7:0]        cmd_r;
   logic [47:0]       max_lba_r;
   logic              armed_r;
   logic              nv_done_r;
   logic              load_r;
   logic              err_r;
   logic              abort_flag_r;
   logic              mult_en_r;
   logic [7:0]        mult_blk_r;
   logic [63:0]       id100_r;
   logic [31:0]       id60_r;
   logic              nv_store_r;
   logic              rej_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_mask_r;
   logic [31:0]       prdata_r;

   // Bus decode.
   wire        setup_ph = PSEL & ~PENABLE;
   wire        acc_ph   = PSEL & PENABLE;
   wire        aligned  = (PADDR[1:0] == 2'b00);
   wire        sel_tf   = aligned & (PADDR < OFS_TF_END);
   wire        sel_cmd  = aligned & (PADDR == OFS_CMD_STAT);
   wire        sel_err  = aligned & (PADDR == OFS_ERROR);
   wire        sel_ist  = aligned & (PADDR == OFS_IRQ_STAT);
   wire        sel_imsk = aligned & (PADDR == OFS_IRQ_MASK);
   wire        sel_maxl = aligned & (PADDR == OFS_MAX_LO);
   wire        sel_maxh = aligned & (PADDR == OFS_MAX_HI);
   wire        sel_mult = aligned & (PADDR == OFS_MULT);
   wire        hit      = sel_tf | sel_cmd | sel_err | sel_ist | sel_imsk |
                          sel_maxl | sel_maxh | sel_mult;
   wire        wr_en    = acc_ph & PWRITE & hit;
   wire        rd_ist   = acc_ph & ~PWRITE & sel_ist;
   wire [2:0]  tf_idx   = PADDR[4:2];

   // Command execution decode.
   wire        idle     = (state_r == ST_IDLE);
   wire        exec     = (state_r == ST_EXEC);
   wire        cmd_go   = wr_en & sel_cmd & idle;
   wire        is_set   = exec & (cmd_r == OPC_SET_MAX_EXT);
   wire        is_mult  = exec & (cmd_r == OPC_SET_MULT);
   wire        is_rdn   = exec & (cmd_r == OPC_RD_NATIVE_EXT);
   wire        is_other = exec & ~is_set & ~is_mult & ~is_rdn;
   wire [47:0] req_lba  = {tf_r[7], tf_r[6], tf_r[5],
                           tf_r[4], tf_r[3], tf_r[2]};
   wire        nv_req   = tf_r[TF_SC_CUR][SC_NV_BIT];
   wire [63:0] native_tf = {NATIVE_MAX_LBA, 16'h0000};

   // Grounds for refusing the extended set.
   wire        set_bad  = ~EXT_SUPPORTED |
                          (req_lba > NATIVE_MAX_LBA) |
                          HPA28_ACTIVE |
                          ~armed_r |
                          SETMAX_LOCKED |
                          SETMAX_FROZEN |
                          (nv_req & OFFSET_MODE) |
                          (nv_req & nv_done_r);
   wire        set_ok   = is_set & ~set_bad;

   wire [7:0]  bs       = tf_r[TF_SC_CUR];
   wire        bs_ok    = (bs <= MULT_MAX) &
                          ((bs & (bs - 8'h01)) == 8'h00);
   wire        abort    = (is_set & set_bad) | (is_mult & ~bs_ok) | is_other;

   // Once after every reset the maximum is reloaded: the retained one if nonzero and within native, else native.
   wire        nv_ok     = (NV_MAX_LBA != 48'h0) & (NV_MAX_LBA <= NATIVE_MAX_LBA);
   wire        apply     = load_r | set_ok;
   wire [47:0] apply_val = load_r ? (nv_ok ? NV_MAX_LBA : NATIVE_MAX_LBA) : req_lba;

   wire        ev_rej   = ACCESS_REQ & (ACCESS_LBA > max_lba_r);
   wire [IRQ_W-1:0] ev  = {ev_rej, abort, exec & ~abort};
   wire [IRQ_W-1:0] ist_clr = rd_ist ? prdata_r[IRQ_W-1:0] : '0;

   wire [7:0]  status_b = (8'(exec) << ST_BSY) | (8'h01 << ST_RDY) |
                          (8'h01 << ST_SEEK_DONE) | (8'(err_r) << ST_ERR);
   wire [7:0]  error_b  = 8'(abort_flag_r) << ERR_ABORT;
   wire [31:0] rd_mux   = sel_tf   ? {24'h0, tf_r[tf_idx]} :
                          sel_cmd  ? {24'h0, status_b} :
                          sel_err  ? {24'h0, error_b} :
                          sel_ist  ? {29'h0, irq_stat_r} :
                          sel_imsk ? {29'h0, irq_mask_r} :
                          sel_maxl ? max_lba_r[31:0] :
                          sel_maxh ? {16'h0, max_lba_r[47:32]} :
                          sel_mult ? {23'h0, mult_en_r, mult_blk_r} : 32'h0;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (cmd_go) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // Task-file bytes; host writes are ignored while a command runs.
   generate
      for (genvar i = 0; i < TF_N; i++) begin : g_tf
         always_ff @(posedge CLK_SYS) begin
            if (RST) begin
               tf_r[i] <= 8'h00;
            end else if (is_rdn && (i >= TF_LBA0)) begin
               tf_r[i] <= native_tf[8*i +: 8];
            end else if (wr_en && sel_tf && idle && (tf_idx == 3'(i))) begin
               tf_r[i] <= PWDATA[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         state_r <= ST_IDLE;
         cmd_r   <= 8'h00;
         armed_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (cmd_go) begin
            cmd_r <= PWDATA[7:0];
         end
         if (exec) begin
            armed_r <= is_rdn;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         load_r     <= 1'b1;
         nv_done_r  <= 1'b0;
         nv_store_r <= 1'b0;
         max_lba_r  <= NATIVE_MAX_LBA;
         id100_r    <= {16'h0000, NATIVE_MAX_LBA};
         id60_r     <= ID60_RST;
      end else begin
         load_r     <= 1'b0;
         nv_store_r <= set_ok & nv_req;
         if (set_ok && nv_req) begin
            nv_done_r <= 1'b1;
         end
         if (apply) begin
            max_lba_r <= apply_val;
            id100_r   <= {16'h0000, apply_val};
            if (apply_val <= LBA28_LIMIT) begin
               id60_r <= apply_val[31:0];
            end
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         mult_en_r  <= 1'b0;
         mult_blk_r <= MULT_RST;
         err_r      <= 1'b0;
         abort_flag_r <= 1'b0;
      end else begin
         if (is_mult) begin
            mult_blk_r <= bs_ok ? bs : MULT_RST;
            mult_en_r  <= bs_ok & (bs != 8'h00);
         end
         if (abort) begin
            err_r <= 1'b1;
            abort_flag_r <= 1'b1;
         end else if (cmd_go) begin
            err_r <= 1'b0;
            abort_flag_r <= 1'b0;
         end
      end
   end

   // A read clears only the bits it returned, so a new event is never lost.
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         irq_stat_r <= '0;
         irq_mask_r <= IRQ_MASK_RST;
         prdata_r   <= 32'h0;
         rej_r      <= 1'b0;
      end else begin
         irq_stat_r <= (irq_stat_r & ~ist_clr) | ev;
         if (wr_en && sel_imsk) begin
            irq_mask_r <= PWDATA[IRQ_W-1:0];
         end
         if (setup_ph) begin
            prdata_r <= rd_mux;
         end
         rej_r <= ev_rej;
      end
   end

   assign PRDATA        = prdata_r;
   assign PREADY        = 1'b1;
   assign PSLVERR       = acc_ph & ~hit;
   assign IRQ           = |(irq_stat_r & irq_mask_r);
   assign NV_STORE      = nv_store_r;
   assign NV_STORE_LBA  = max_lba_r;
   assign ID_W100_103   = id100_r;
   assign ID_W60_61     = id60_r;
   assign MULT_EN       = mult_en_r;
   assign MULT_BLOCK    = mult_blk_r;
   assign ACCESS_REJECT = rej_r;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   AST_SET_APPLY: assert property (
      set_ok |=> max_lba_r == $past(req_lba) && err_r == 1'b0)
      else $error("accepted set did not load the new maximum");
   AST_UNARMED: assert property (
      is_set && !armed_r |=> abort_flag_r && !armed_r && max_lba_r == $past(max_lba_r))
      else $error("set accepted without a preceding native read");
   AST_REJECT: assert property (
      ACCESS_REQ && (ACCESS_LBA > max_lba_r) |=> ACCESS_REJECT && irq_stat_r[IRQ_REJECT])
      else $error("access beyond maximum was not rejected");
   AST_ID60_HOLD: assert property (
      set_ok && (req_lba > LBA28_LIMIT) |=> $stable(id60_r) && id100_r[47:0] == $past(req_lba))
      else $error("large maximum touched 28-bit words");
   AST_ID60_UPD: assert property (
      set_ok && (req_lba <= LBA28_LIMIT) |=> {16'h0000, id60_r} == $past(req_lba))
      else $error("small maximum did not update 28-bit words");
   AST_SET_BAD: assert property (
      is_set && (HPA28_ACTIVE || SETMAX_LOCKED) |=> abort_flag_r && $stable(max_lba_r))
      else $error("set accepted despite protected area or lock");
   AST_NV_ONCE: assert property (
      is_set && nv_req && nv_done_r |=> err_r && !NV_STORE)
      else $error("second non-volatile set was accepted");
   AST_NV_STORE: assert property (
      set_ok && nv_req |=> NV_STORE ##1 !NV_STORE)
      else $error("non-volatile set not stored for one cycle");
   AST_OFFSET_NV: assert property (
      is_set && nv_req && OFFSET_MODE |=> abort_flag_r && max_lba_r == $past(max_lba_r))
      else $error("non-volatile set accepted in offset mode");
   AST_MULT_OK: assert property (
      is_mult && bs_ok && (bs != 8'h00) |=> MULT_EN && MULT_BLOCK == $past(bs))
      else $error("valid block size not applied");
   AST_MULT_BAD: assert property (
      is_mult && !bs_ok |=> !MULT_EN && abort_flag_r && irq_stat_r[IRQ_ABORT])
      else $error("invalid block size not aborted");
   AST_MULT_ZERO: assert property (
      is_mult && (bs == 8'h00) |=> !MULT_EN && !err_r)
      else $error("zero block size handled wrongly");
   AST_FROZEN: assert property (
      is_set && SETMAX_FROZEN |=> abort_flag_r)
      else $error("set accepted while frozen");
   AST_ABORT_FLAGS: assert property (
      abort |=> !exec && status_b[ST_ERR] && error_b == (8'h01 << ERR_ABORT))
      else $error("abort flags wrong");
   AST_CAP_LIMIT: assert property (
      is_set && (req_lba > NATIVE_MAX_LBA) |=> abort_flag_r && $stable(max_lba_r))
      else $error("maximum above capacity was accepted");
   AST_NATIVE_ARM: assert property (
      is_rdn |=> armed_r && req_lba == NATIVE_MAX_LBA)
      else $error("native read did not load the layers or arm");
   AST_CMD_CLEAR: assert property (
      cmd_go |=> exec && !err_r && !abort_flag_r)
      else $error("new command did not clear the error flags");
   AST_BUSY_END: assert property (
      cmd_go |=> status_b[ST_BSY] ##1 !status_b[ST_BSY])
      else $error("busy did not clear after one cycle");
   AST_ABORT_IRQ: assert property (
      abort |=> irq_stat_r[IRQ_ABORT])
      else $error("abort did not raise its interrupt status bit");
   AST_VOL_NO_STORE: assert property (
      set_ok && !nv_req |=> !NV_STORE)
      else $error("volatile set requested a non-volatile store");
   AST_NO_REJECT: assert property (
      ACCESS_REQ && (ACCESS_LBA <= max_lba_r) |=> !ACCESS_REJECT)
      else $error("access within maximum was rejected");
   AST_MAX_HOLD: assert property (
      !apply |=> $stable(max_lba_r))
      else $error("maximum changed without an accepted set");
   AST_MULT_HOLD: assert property (
      !is_mult |=> $stable(MULT_BLOCK) && $stable(MULT_EN))
      else $error("block size changed without a block-size command");
   AST_MULT_BAD_BLK: assert property (
      is_mult && !bs_ok |=> MULT_BLOCK == MULT_RST)
      else $error("invalid block size was stored");
   AST_ID60_LIMIT: assert property (
      ID_W60_61 <= LBA28_LIMIT[31:0])
      else $error("28-bit capacity words exceed the 28-bit limit");
endmodule
`default_nettype wire

//--- sim/mbs_host.sv
// Host-side APB master model that feeds the task file and command register.
// Assumes one clock; the caller decides command order and spacing.
`timescale 1ns/1ps
`default_nettype none
module mbs_host (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end
   // One transfer; the request is held until pready is seen high at an edge.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- sim/tb_mbs_cmd_core.sv
// Self-checking bench for mbs_cmd_core: limit set, block size, irq, bus errors.
// Assumes the host model in mbs_host.sv and the constants of mbs_pkg.
`timescale 1ns/1ps
`default_nettype none
module tb_mbs_cmd_core;
   import mbs_pkg::*;
   localparam logic [47:0] NATIVE = 48'h0000_ffff_ffff;
   logic        clk_sys = 1'b0, rst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq, nv_store, mult_en, acc_rej;
   logic        offs = 1'b0, locked = 1'b0, frozen = 1'b0, hpa = 1'b0, acc_req = 1'b0;
   logic [7:0]  paddr, mult_block;
   logic [31:0] pwdata, prdata, id_lo, q;
   logic [63:0] id_hi;
   logic [47:0] nv_lba = 48'h0, store_lba, acc_lba = 48'h0;
   logic        e, nv_seen;
   int          n_errors = 0, compares = 0;
   always #2.5 clk_sys = ~clk_sys;
   mbs_host host (.clk(clk_sys), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   mbs_cmd_core #(.NATIVE_MAX_LBA(NATIVE)) DUT (.CLK_SYS(clk_sys), .RST(rst),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
      .OFFSET_MODE(offs), .SETMAX_LOCKED(locked), .SETMAX_FROZEN(frozen),
      .HPA28_ACTIVE(hpa), .NV_MAX_LBA(nv_lba), .NV_STORE(nv_store),
      .NV_STORE_LBA(store_lba), .ID_W100_103(id_hi), .ID_W60_61(id_lo),
      .MULT_EN(mult_en), .MULT_BLOCK(mult_block), .ACCESS_REQ(acc_req),
      .ACCESS_LBA(acc_lba), .ACCESS_REJECT(acc_rej));
   task automatic chk(input string w, input logic [63:0] seen, input logic [63:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", w, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic rd_chk(input string w, input logic [7:0] a, input logic [31:0] x);
      host.xfer(1'b0, a, 32'h0, q, e);
      chk(w, q, x);
      chk("slverr_ok", e, 1'b0);
   endtask
   // Loads sector count and the six address bytes, then issues the opcode.
   task automatic cmd(input logic [7:0] op, input logic [7:0] sc, input logic [47:0] lba);
      host.xfer(1'b1, 8'h00, {24'h0, sc}, q, e);
      for (int i = 0; i < 6; i++) host.xfer(1'b1, 8'(8 + 4 * i), {24'h0, lba[8*i +: 8]}, q, e);
      host.xfer(1'b1, OFS_CMD_STAT, {24'h0, op}, q, e);
      @(posedge clk_sys);
      #1 nv_seen = nv_store;
      @(posedge clk_sys);
   endtask
   task automatic setmax(input logic [47:0] lba, input logic b);
      cmd(8'h27, 8'h00, 48'h0);
      cmd(OPC_SET_MAX_EXT, {7'h0, b}, lba);
   endtask
   task automatic result(input logic ok);
      rd_chk("status", OFS_CMD_STAT, ok ? 32'h50 : 32'h51);
      rd_chk("error", OFS_ERROR, ok ? 32'h0 : 32'h4);
   endtask
   task automatic access(input logic [47:0] lba, input logic exp);
      @(posedge clk_sys);
      acc_req <= 1'b1;
      acc_lba <= lba;
      @(posedge clk_sys);
      acc_req <= 1'b0;
      #1 chk("reject", acc_rej, exp);
   endtask
   task automatic t_volatile;
      rd_chk("max_lo", OFS_MAX_LO, 32'hffff_ffff);
      setmax(48'h1234, 1'b0);
      result(1'b1);
      rd_chk("max_lo", OFS_MAX_LO, 32'h1234);
      rd_chk("max_hi", OFS_MAX_HI, 32'h0);
      chk("id60", id_lo, 32'h1234);
      chk("id100", id_hi, 64'h1234);
      chk("nv_store_vol", nv_seen, 1'b0);
      chk("irq_masked", irq, 1'b0);
      host.xfer(1'b1, OFS_IRQ_MASK, 32'h7, q, e);
      @(posedge clk_sys);
      #1 chk("irq_on", irq, 1'b1);
      rd_chk("irq_stat", OFS_IRQ_STAT, 32'h1);
      @(posedge clk_sys);
      #1 chk("irq_off", irq, 1'b0);
   endtask
   task automatic t_access;
      access(48'h1234, 1'b0);
      access(48'h1235, 1'b1);
      @(posedge clk_sys);
      #1 chk("irq_rej", irq, 1'b1);
      rd_chk("irq_stat", OFS_IRQ_STAT, 32'h4);
      host.xfer(1'b0, 8'h40, 32'h0, q, e);
      chk("slverr", e, 1'b1);
      chk("pready", pready, 1'b1);
   endtask
   // Offset mode, frozen, locked, old protected area, too large, not armed.
   task automatic t_aborts;
      for (int i = 0; i < 6; i++) begin
         {hpa, locked, frozen, offs} <= 4'(i < 4 ? 1 << i : 0);
         if (i == 5) cmd(OPC_SET_MAX_EXT, 8'h00, 48'h10);
         else setmax(i == 4 ? NATIVE + 48'h1 : 48'h10, i == 0);
         result(1'b0);
      end
      rd_chk("max_kept", OFS_MAX_LO, 32'h1234);
      cmd(8'h00, 8'h00, 48'h0);
      result(1'b0);
      rd_chk("irq_abt", OFS_IRQ_STAT, 32'h3);
   endtask
   task automatic t_nv;
      setmax(48'h1000_0000, 1'b1);
      result(1'b1);
      chk("nv_store", nv_seen, 1'b1);
      chk("nv_lba", store_lba, 48'h1000_0000);
      chk("id60_kept", id_lo, 32'h1234);
      chk("id100", id_hi, 64'h1000_0000);
      setmax(48'h2000, 1'b1);
      result(1'b0);
   endtask
   task automatic t_mult;
      logic [7:0] sz [9] = '{8'h10, 8'h03, 8'h01, 8'h02, 8'h04, 8'h08, 8'h00, 8'h11, 8'h20};
      logic       ok;
      for (int i = 0; i < 9; i++) begin
         ok = sz[i] inside {8'h0, 8'h1, 8'h2, 8'h4, 8'h8, 8'h10};
         cmd(OPC_SET_MULT, sz[i], 48'h0);
         result(ok);
         chk("mult_en", mult_en, ok && sz[i] != 8'h0);
         chk("mult_block", mult_block, ok ? sz[i] : 8'h0);
      end
      rd_chk("mult_reg", OFS_MULT, 32'h0);
   endtask
   task automatic t_reset_nv;
      nv_lba <= 48'h5000;
      rst <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rd_chk("max_nv", OFS_MAX_LO, 32'h5000);
      chk("id60_nv", id_lo, 32'h5000);
      setmax(48'h6000, 1'b1);
      result(1'b1);
   endtask
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'b0;
      t_volatile();
      t_access();
      t_aborts();
      t_nv();
      t_mult();
      t_reset_nv();
      end_of_test();
   end
   initial begin
      #100000;
      n_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
